/* File: core/dio_pkg.sv */
package elp_pkg;

  // ----------------------------------------------------------------
  // Configuration unlock value, device number and activate value
  // ----------------------------------------------------------------
  localparam logic [7:0] ELP_UNLOCK_VALUE = 8'h87;
  localparam logic [7:0] ELP_DEVICE_NUMBER = 8'h08;
  localparam logic [7:0] ELP_ACTIVATE_VALUE = 8'h02;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ELP_REG_LOGICAL_DEVICE_SELECT = 8'h07;
  localparam logic [7:0] ELP_REG_FUNCTION_ACTIVATE = 8'h30;
  localparam logic [7:0] ELP_REG_LINE_DIRECTION = 8'hE0;
  localparam logic [7:0] ELP_REG_LINE_VALUE = 8'hE1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ELP_RST_INDEX = 8'h00;
  localparam logic [7:0] ELP_RST_LOGICAL_DEVICE = 8'h00;
  localparam logic [7:0] ELP_RST_FUNCTION_ACTIVATE = 8'h00;
  localparam logic [7:0] ELP_RST_LINE_DIRECTION = 8'hFF;
  localparam logic [7:0] ELP_RST_LINE_VALUE = 8'h00;
  localparam logic [7:0] ELP_RST_READ_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Host port request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel_data;
    logic [7:0] wdata;
  } elp_req_t;

  // Unlock sequence states
  typedef enum logic [1:0] {
    ELP_LOCKED,
    ELP_HALF_OPEN,
    ELP_OPEN
  } elp_lock_t;

endpackage

/* File: core/dio_sync.sv */
`timescale 1ns/100ps
module elp_sync import elp_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Asynchronous data in, synchronised data out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

/* File: core/dio_port.sv */
`timescale 1ns/100ps
module elp_port import elp_pkg::*; #(
  parameter int LINES = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Host index/data port
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic host_sel_data_in,
  input wire logic [7:0] host_wdata_in,
  output logic [7:0] host_rdata_out,
  output logic host_rvalid_out,
  // Digital lines, enable low while driving
  input wire logic [LINES-1:0] digital_line_in,
  output logic [LINES-1:0] digital_line_out,
  output logic [LINES-1:0] digital_line_oe_b_out,
  // Status
  output logic config_open_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Host request and unlock progress
  elp_req_t req;
  elp_lock_t lock_state;
  elp_lock_t next_lock_state;
  // Index, logical device select and configuration registers of our logical device
  logic [7:0] index_reg;
  logic [7:0] logical_device;
  logic [7:0] function_activate;
  logic [7:0] line_direction;
  logic [7:0] output_value_byte;
  // Pin levels after the synchroniser
  logic [LINES-1:0] line_level;

  // ----------------------------------------------------------------
  // Decode wires
  // ----------------------------------------------------------------
  // Strobe qualifiers
  logic port_open;
  logic index_wr;
  logic data_wr;
  logic data_rd;
  logic is_unlock;
  // Register hits on the current index
  logic dev_selected;
  logic dev_wr;
  logic hit_ldn;
  logic hit_act;
  logic hit_dir;
  logic hit_val;
  // Line control and read path
  logic active;
  logic [LINES-1:0] drive_mask;
  logic [LINES-1:0] value_view;
  logic [7:0] read_mux;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Bundle the host strobes so the decode reads one carrier
  assign req = '{wr: host_wr_in, rd: host_rd_in, sel_data: host_sel_data_in,
                 wdata: host_wdata_in};

  // Index writes always reach the unlock logic; data writes need an open port
  assign port_open = (lock_state == ELP_OPEN);
  assign index_wr = req.wr && !req.sel_data;
  assign data_wr = req.wr && req.sel_data && port_open;
  assign data_rd = req.rd && req.sel_data;
  assign is_unlock = index_wr && (req.wdata == ELP_UNLOCK_VALUE);

  // Device registers only answer once our logical device is chosen
  assign dev_selected = (logical_device == ELP_DEVICE_NUMBER);
  assign dev_wr = data_wr && dev_selected;
  assign hit_ldn = (index_reg == ELP_REG_LOGICAL_DEVICE_SELECT);
  assign hit_act = (index_reg == ELP_REG_FUNCTION_ACTIVATE);
  assign hit_dir = (index_reg == ELP_REG_LINE_DIRECTION);
  assign hit_val = (index_reg == ELP_REG_LINE_VALUE);

  // A zero direction bit drives its line, but only once the function is active
  assign active = (function_activate == ELP_ACTIVATE_VALUE);
  assign drive_mask = active ? ~line_direction[LINES-1:0] : '0;

  // Inputs show the pin, outputs show the latched level
  assign value_view = (line_level & ~drive_mask) |
    (output_value_byte[LINES-1:0] & drive_mask);

  // Read data selection; closed or unknown reads give zero
  assign read_mux =
    !port_open ? ELP_RST_READ_DATA :
    hit_ldn ? logical_device :
    !dev_selected ? ELP_RST_READ_DATA :
    hit_act ? function_activate :
    hit_dir ? line_direction :
    hit_val ? 8'(value_view) : ELP_RST_READ_DATA;

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  // Two 87 writes in a row open; any other write while
  // half open drops back, so a stray byte cannot unlock
  always_comb begin
    next_lock_state = lock_state;
    unique case (lock_state)
      ELP_LOCKED: begin
        if (is_unlock) begin
          next_lock_state = ELP_HALF_OPEN;
        end
      end
      ELP_HALF_OPEN: begin
        if (is_unlock) begin
          next_lock_state = ELP_OPEN;
        end else if (req.wr) begin
          next_lock_state = ELP_LOCKED;
        end
      end
      ELP_OPEN: begin
        next_lock_state = ELP_OPEN;
      end
    endcase
  end

  // Unlock state; only reset closes the port again
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_state <= ELP_LOCKED;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // ----------------------------------------------------------------
  // Index and configuration registers
  // ----------------------------------------------------------------
  // Index latch; held while closed so unlock bytes never land here
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      index_reg <= ELP_RST_INDEX;
    end else if (index_wr && port_open) begin
      index_reg <= req.wdata;
    end
  end

  // Logical device number, writable before our device is chosen
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      logical_device <= ELP_RST_LOGICAL_DEVICE;
    end else if (data_wr && hit_ldn) begin
      logical_device <= req.wdata;
    end
  end

  // Device registers, written only with our device selected
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      function_activate <= ELP_RST_FUNCTION_ACTIVATE;
      line_direction <= ELP_RST_LINE_DIRECTION;
      output_value_byte <= ELP_RST_LINE_VALUE;
    end else begin
      if (dev_wr && hit_act) begin
        function_activate <= req.wdata;
      end
      if (dev_wr && hit_dir) begin
        line_direction <= req.wdata;
      end
      if (dev_wr && hit_val) begin
        output_value_byte <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line input synchroniser
  // ----------------------------------------------------------------
  // Pins are asynchronous; reads see them two cycles late
  elp_sync #(
    .WIDTH(LINES)
  ) u_line_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in(digital_line_in),
    .sync_out(line_level)
  );

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  // Pins released until the function is active; a half-set
  // direction byte drives only the lines whose bit is zero
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      digital_line_out <= '0;
      digital_line_oe_b_out <= '1;
    end else begin
      digital_line_out <= output_value_byte[LINES-1:0];
      digital_line_oe_b_out <= ~drive_mask;
    end
  end

  // Read answer one cycle after the strobe; data holds until the next read
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      host_rdata_out <= ELP_RST_READ_DATA;
      host_rvalid_out <= 1'b0;
    end else begin
      host_rvalid_out <= data_rd;
      if (data_rd) begin
        host_rdata_out <= read_mux;
      end
    end
  end

  // Open flag rises with the state, so both agree on every cycle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      config_open_out <= 1'b0;
    end else begin
      config_open_out <= (next_lock_state == ELP_OPEN);
    end
  end

endmodule

/* File: test/dio_props.sv */
`timescale 1ns/100ps
module elp_props import elp_pkg::*; #(
  parameter int LINES = 8
) (
  // Clock, reset and host side
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic host_sel_data_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic [7:0] host_rdata_out,
  input wire logic host_rvalid_out,
  // Lines and status
  input wire logic [LINES-1:0] digital_line_out,
  input wire logic [LINES-1:0] digital_line_oe_b_out,
  input wire logic config_open_out
);
  // ----------------
  // Port properties
  // ----------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  // Data port strobes
  wire dwr = host_wr_in && host_sel_data_in;
  wire drd = host_rd_in && host_sel_data_in;
  property p_rv; drd |=> host_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("no read pulse");
  property p_oe; !config_open_out |-> &digital_line_oe_b_out; endproperty
  a_oe: assert property (p_oe) else $error("driving while locked");
  property p_op; $rose(config_open_out) |-> $past(host_wr_in && !host_sel_data_in
    && host_wdata_in == ELP_UNLOCK_VALUE); endproperty
  a_op: assert property (p_op) else $error("open without unlock");
  property p_rs; !$past(drd) |-> $stable(host_rdata_out); endproperty
  a_rs: assert property (p_rs) else $error("read data moved");
  // Register then output flop: a write shows on the pins two edges later
  property p_lo; $changed(digital_line_out) |-> $past(dwr, 2); endproperty
  a_lo: assert property (p_lo) else $error("levels moved");
  property p_oc; $changed(digital_line_oe_b_out) |-> $past(dwr, 2); endproperty
  a_oc: assert property (p_oc) else $error("direction moved");
  property p_rf; !config_open_out && drd |=> host_rdata_out == 8'h00; endproperty
  a_rf: assert property (p_rf) else $error("locked read not zero");
  property p_lk; config_open_out |=> config_open_out; endproperty
  a_lk: assert property (p_lk) else $error("relocked");
  c_open: cover property ($rose(config_open_out));
  c_drv: cover property (digital_line_oe_b_out == '0);
  c_rd: cover property (host_rvalid_out && &digital_line_oe_b_out);
endmodule

/* File: test/dio_lines_model.sv */
`timescale 1ns/100ps
module elp_lines_model (
  // Clock and design side of pins
  input wire logic clock_in,
  input wire logic [7:0] line_drive_in,
  input wire logic [7:0] line_oe_b_in,
  // Far-side source set by the bench
  input wire logic ext_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] pin_level_out
);
  logic [7:0] float_q = 8'h55;
  // Floating pins wander so a stale level never reads as valid;
  // plain always since the start value comes from the declaration
  always @(posedge clock_in) begin
    float_q <= ~float_q;
  end
  // Design wins on the bits it drives
  assign pin_level_out = (line_drive_in & ~line_oe_b_in)
    | ((ext_en_in ? ext_val_in : float_q) & line_oe_b_in);
endmodule

/* File: test/dio_port_tb_top.sv */
`timescale 1ns/100ps
module elp_port_tb_top;
  import elp_pkg::*;
  logic clock_in = 0, rst_b_in = 0, wr = 0, rd = 0, sd = 0, ext_en = 0, rv, open;
  logic [7:0] wd = 8'h00, ext_val = 8'h00, rdat, lout, oeb, pins;
  int err_count = 0, samples_checked = 0;
  elp_port u_elp_port (.clock_in, .rst_b_in, .host_wr_in(wr), .host_rd_in(rd),
    .host_sel_data_in(sd), .host_wdata_in(wd), .host_rdata_out(rdat), .host_rvalid_out(rv),
    .digital_line_in(pins), .digital_line_out(lout), .digital_line_oe_b_out(oeb),
    .config_open_out(open));
  elp_lines_model u_elp_lines_model (.clock_in, .line_drive_in(lout), .line_oe_b_in(oeb),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_level_out(pins));
  // ----------------
  // Host port tasks
  // ----------------
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic s, input logic [7:0] d);
    @(negedge clock_in);
    wr = 1;
    sd = s;
    wd = d;
    @(negedge clock_in);
    wr = 0;
  endtask
  // Bounded wait for the read pulse; a miss counts as a mismatch
  task automatic get(input logic [7:0] idx, input logic [7:0] exp);
    int n;
    put(1'b0, idx);
    @(negedge clock_in);
    rd = 1;
    sd = 1;
    @(negedge clock_in);
    rd = 0;
    for (n = 0; n < 4 && rv !== 1'b1; n++)
      @(negedge clock_in);
    chk({7'h00, rv}, 8'h01);
    chk(rdat, exp);
  endtask
  task automatic s_locked();
    chk(oeb, 8'hFF);
    put(1'b0, 8'h07);
    put(1'b1, 8'h08);
    get(8'hE1, 8'h00);
    put(1'b0, 8'h87);
    put(1'b0, 8'h00);
    put(1'b0, 8'h87);
    @(negedge clock_in);
    chk({7'h00, open}, 8'h00);
    put(1'b0, 8'h87);
    @(negedge clock_in);
    chk({7'h00, open}, 8'h01);
  endtask
  // Direction write before the device is chosen must be ignored
  task automatic s_output();
    put(1'b0, 8'hE0);
    put(1'b1, 8'h00);
    put(1'b0, 8'h07);
    put(1'b1, 8'h08);
    get(8'h07, 8'h08);
    get(8'hE0, 8'hFF);
    put(1'b0, 8'hE0);
    put(1'b1, 8'h00);
    put(1'b0, 8'hE1);
    put(1'b1, 8'h4D);
    @(negedge clock_in);
    chk(oeb, 8'hFF);
    put(1'b0, 8'h30);
    put(1'b1, 8'h02);
    @(negedge clock_in);
    chk(oeb, 8'h00);
    chk(lout, 8'h4D);
    get(8'hE1, 8'h4D);
    get(8'h30, 8'h02);
  endtask
  // Non-symmetric bytes so a reversed bit order cannot pass
  task automatic s_input();
    ext_en = 1;
    ext_val = 8'h3A;
    put(1'b0, 8'hE0);
    put(1'b1, 8'hFF);
    @(negedge clock_in);
    chk(oeb, 8'hFF);
    repeat (3) @(negedge clock_in);
    get(8'hE1, 8'h3A);
    put(1'b0, 8'hE0);
    put(1'b1, 8'hF0);
    @(negedge clock_in);
    chk(oeb, 8'hF0);
    get(8'hE1, 8'h3D);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock_in);
    rst_b_in = 1;
    s_locked();
    s_output();
    s_input();
    print_verdict();
  end
endmodule
bind elp_port elp_props #(.LINES(LINES)) u_elp_props (.clock_in, .rst_b_in, .host_wr_in,
  .host_rd_in, .host_sel_data_in, .host_wdata_in, .host_rdata_out, .host_rvalid_out,
  .digital_line_out, .digital_line_oe_b_out, .config_open_out);
